// file: rtl/crf_pkg.sv
// constants for the cluster internal reset fan-out block
// assumes a 32-bit wishbone register bus, byte addressed
package crf_pkg;

   // cluster sizes, one reset bit per core
   localparam int CRF_DUO_CORES = 2;
   localparam int CRF_TRIO_CORES = 3;

   // register map, byte addresses
   localparam int CRF_ADR_W = 8;
   localparam logic [CRF_ADR_W-1:0] CRF_ADR_RESET_CTRL = 8'h00;
   localparam logic [CRF_ADR_W-1:0] CRF_ADR_RESET_STAT = 8'h04;

   // reset_control_reg reset value: every internal reset released
   localparam logic [31:0] CRF_RESET_CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] CRF_RESET_CTRL_MASK = 32'h0fff_ffff;

   // reset_control_reg field positions, a set bit requests reset
   localparam int CRF_DUO_FULL_LSB = 0;
   localparam int CRF_DUO_EXEC_LSB = 2;
   localparam int CRF_DUO_SIMD_LSB = 4;
   localparam int CRF_DUO_DEBUG_LSB = 6;
   localparam int CRF_DUO_SHDBG_BIT = 8;
   localparam int CRF_DUO_L2_BIT = 9;
   localparam int CRF_DUO_CDOM_BIT = 10;
   localparam int CRF_DUO_IFACE_BIT = 11;
   localparam int CRF_TRIO_FULL_LSB = 12;
   localparam int CRF_TRIO_EXEC_LSB = 15;
   localparam int CRF_TRIO_DEBUG_LSB = 18;
   localparam int CRF_TRIO_TRACE_LSB = 21;
   localparam int CRF_TRIO_SYSDBG_BIT = 24;
   localparam int CRF_TRIO_L2_BIT = 25;
   localparam int CRF_TRIO_CDOM_BIT = 26;
   localparam int CRF_TRIO_IFACE_BIT = 27;

   // reset synchroniser depth
   localparam int CRF_SYNC_STAGES = 2;

endpackage : crf_pkg

// file: rtl/crf_rst_sync.sv
// reset synchroniser: asserts at once, releases after STAGES target clock edges
// assumes rst_req_i comes straight from a flip-flop so it cannot glitch
`timescale 1ns/1ps
module crf_rst_sync #(
   parameter int WIDTH = 1,
   parameter int STAGES = 2
) (
   // target domain
   input wire logic clk_i,
   // active-high requests
   input wire logic [WIDTH-1:0] rst_req_i,
   // active-low resets
   output logic [WIDTH-1:0] rst_n_o
);

   genvar g;
   generate
      for (g = 0; g < WIDTH; g++) begin : g_bit
         logic [STAGES-1:0] sh_q;
         // async assert, sync release
         always_ff @(posedge clk_i or posedge rst_req_i[g]) begin
            if (rst_req_i[g]) begin
               sh_q <= '0;
            end else begin
               sh_q <= {sh_q[STAGES-2:0], 1'b1};
            end
         end
         assign rst_n_o[g] = sh_q[STAGES-1];
      end
   endgenerate

endmodule : crf_rst_sync

// file: rtl/crf_reset_fanout.sv
// cluster internal reset fan-out with its reset control register
// assumes a classic wishbone master on clk_i and free-running cluster and system clocks
//
// Functional notes
// - per-core full reset covers core, simd, debug, trace and breakpoint logic
// - per-core exec reset covers only the core and its simd unit
// - duo cluster has a per-core reset for the simd unit alone
// - per-core debug reset covers debug, trace and breakpoint logic only
// - trio cluster has a per-core trace reset for trace and breakpoint logic
// - duo shared-debug reset covers shared debug logic and overrides fine resets; here it drives only duo_shared_debug_reset_n_o
// - trio system debug reset covers all debug logic, not cores or l2
// - each cluster l2 reset covers l2, interrupt and timer logic, overriding fine resets; here it drives only its l2 reset output
// - each core-domain reset covers the whole core domain and overrides fine resets
// - core-domain reset always hits every core of the cluster together
// - interface-domain reset covers only the core-to-interface domain logic
// - interface resets sync to the system clock, others to their cluster clock
// - fine reset targets come from separate bits of reset_control_reg
// - these resets are independent of the board hard reset
// - per-core vectors are two bits for duo and three for trio
//
// Chosen here: the address map and register access over Wishbone.
`timescale 1ns/1ps
module crf_reset_fanout
   import crf_pkg::*;
#(
   parameter int SYNC_STAGES = CRF_SYNC_STAGES
) (
   // register clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [CRF_ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // target domain clocks
   input wire logic duo_cluster_clk_i,
   input wire logic trio_cluster_clk_i,
   input wire logic sys_clk_i,
   // duo cluster resets
   output logic [CRF_DUO_CORES-1:0] duo_percore_full_reset_n_o,
   output logic [CRF_DUO_CORES-1:0] duo_percore_exec_reset_n_o,
   output logic [CRF_DUO_CORES-1:0] duo_percore_simd_reset_n_o,
   output logic [CRF_DUO_CORES-1:0] duo_percore_debug_reset_n_o,
   output logic duo_shared_debug_reset_n_o,
   output logic duo_l2_reset_n_o,
   output logic duo_core_domain_reset_n_o,
   output logic duo_iface_domain_reset_n_o,
   // trio cluster resets
   output logic [CRF_TRIO_CORES-1:0] trio_percore_full_reset_n_o,
   output logic [CRF_TRIO_CORES-1:0] trio_percore_exec_reset_n_o,
   output logic [CRF_TRIO_CORES-1:0] trio_percore_debug_reset_n_o,
   output logic [CRF_TRIO_CORES-1:0] trio_percore_trace_reset_n_o,
   output logic trio_system_debug_reset_n_o,
   output logic trio_l2_reset_n_o,
   output logic trio_core_domain_reset_n_o,
   output logic trio_iface_domain_reset_n_o
);

   localparam int DUO_REQ_W = 4 * CRF_DUO_CORES + 3;
   localparam int TRIO_REQ_W = 4 * CRF_TRIO_CORES + 3;

   ////////////////////////////////////////////////////////////////////////////////
   // wishbone slave

   logic [31:0] reset_control_reg_q;
   logic [31:0] reset_control_reg_d;
   logic [31:0] status_q;
   logic ack_q;
   logic [31:0] rdata_q;

   wire access = wb_cyc_i & wb_stb_i & ~ack_q;
   wire hit_ctrl = (wb_adr_i == CRF_ADR_RESET_CTRL);
   wire hit_stat = (wb_adr_i == CRF_ADR_RESET_STAT);
   wire wr_ctrl = access & wb_we_i & hit_ctrl;
   wire [31:0] sel_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   wire [31:0] rdata_d = hit_ctrl ? reset_control_reg_q : (hit_stat ? status_q : 32'h0000_0000);

   // byte-lane write, reserved bits stay zero
   assign reset_control_reg_d = ((reset_control_reg_q & ~sel_mask) | (wb_dat_i & sel_mask)) & CRF_RESET_CTRL_MASK;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         reset_control_reg_q <= CRF_RESET_CTRL_RST;
      end else if (ce_i) begin
         ack_q <= access;
         if (access) begin
            rdata_q <= rdata_d;
         end
         if (wr_ctrl) begin
            reset_control_reg_q <= reset_control_reg_d;
         end
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdata_q;

   ////////////////////////////////////////////////////////////////////////////////
   // reset request decode with overrides

   wire [31:0] c = reset_control_reg_q;

   // duo requests, one bit per core
   wire [CRF_DUO_CORES-1:0] duo_full_b = c[CRF_DUO_FULL_LSB +: CRF_DUO_CORES];
   wire [CRF_DUO_CORES-1:0] duo_exec_b = c[CRF_DUO_EXEC_LSB +: CRF_DUO_CORES];
   wire [CRF_DUO_CORES-1:0] duo_simd_b = c[CRF_DUO_SIMD_LSB +: CRF_DUO_CORES];
   wire [CRF_DUO_CORES-1:0] duo_debug_b = c[CRF_DUO_DEBUG_LSB +: CRF_DUO_CORES];
   wire duo_cdom = c[CRF_DUO_CDOM_BIT];
   wire [CRF_DUO_CORES-1:0] duo_cdom_all = {CRF_DUO_CORES{duo_cdom}};

   // trio requests, one bit per core
   wire [CRF_TRIO_CORES-1:0] trio_full_b = c[CRF_TRIO_FULL_LSB +: CRF_TRIO_CORES];
   wire [CRF_TRIO_CORES-1:0] trio_exec_b = c[CRF_TRIO_EXEC_LSB +: CRF_TRIO_CORES];
   wire [CRF_TRIO_CORES-1:0] trio_debug_b = c[CRF_TRIO_DEBUG_LSB +: CRF_TRIO_CORES];
   wire [CRF_TRIO_CORES-1:0] trio_trace_b = c[CRF_TRIO_TRACE_LSB +: CRF_TRIO_CORES];
   wire trio_cdom = c[CRF_TRIO_CDOM_BIT];
   wire trio_sysdbg = c[CRF_TRIO_SYSDBG_BIT];
   wire [CRF_TRIO_CORES-1:0] trio_cdom_all = {CRF_TRIO_CORES{trio_cdom}};
   wire [CRF_TRIO_CORES-1:0] trio_sysdbg_all = {CRF_TRIO_CORES{trio_sysdbg}};

   // duo effective requests: core domain overrides every fine reset
   wire [CRF_DUO_CORES-1:0] duo_full_r = duo_full_b | duo_cdom_all;
   wire [CRF_DUO_CORES-1:0] duo_exec_r = duo_exec_b | duo_cdom_all;
   wire [CRF_DUO_CORES-1:0] duo_simd_r = duo_simd_b | duo_cdom_all;
   wire [CRF_DUO_CORES-1:0] duo_debug_r = duo_debug_b | duo_cdom_all;
   wire duo_shdbg_r = c[CRF_DUO_SHDBG_BIT] | duo_cdom;
   wire duo_l2_r = c[CRF_DUO_L2_BIT] | duo_cdom;

   // trio effective requests: system debug overrides per-core debug and trace
   wire [CRF_TRIO_CORES-1:0] trio_full_r = trio_full_b | trio_cdom_all;
   wire [CRF_TRIO_CORES-1:0] trio_exec_r = trio_exec_b | trio_cdom_all;
   wire [CRF_TRIO_CORES-1:0] trio_debug_r = trio_debug_b | trio_sysdbg_all | trio_cdom_all;
   wire [CRF_TRIO_CORES-1:0] trio_trace_r = trio_trace_b | trio_sysdbg_all | trio_cdom_all;
   wire trio_sysdbg_r = trio_sysdbg | trio_cdom;
   wire trio_l2_r = c[CRF_TRIO_L2_BIT] | trio_cdom;

   wire [DUO_REQ_W-1:0] duo_req_d = {duo_cdom, duo_l2_r, duo_shdbg_r, duo_debug_r, duo_simd_r, duo_exec_r,
                                     duo_full_r};
   wire [TRIO_REQ_W-1:0] trio_req_d = {trio_cdom, trio_l2_r, trio_sysdbg_r, trio_trace_r, trio_debug_r,
                                       trio_exec_r, trio_full_r};
   wire [1:0] iface_req_d = {c[CRF_TRIO_IFACE_BIT], c[CRF_DUO_IFACE_BIT]};

   ////////////////////////////////////////////////////////////////////////////////
   // registered requests, glitch-free into the async assert of the synchronisers

   logic [DUO_REQ_W-1:0] duo_req_q;
   logic [TRIO_REQ_W-1:0] trio_req_q;
   logic [1:0] iface_req_q;

   // board hard reset is not an input here, so these run independently of it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         duo_req_q <= '0;
         trio_req_q <= '0;
         iface_req_q <= 2'h0;
         status_q <= 32'h0000_0000;
      end else if (ce_i) begin
         duo_req_q <= duo_req_d;
         trio_req_q <= trio_req_d;
         iface_req_q <= iface_req_d;
         status_q <= {4'h0, iface_req_q[1], trio_req_q[TRIO_REQ_W-1:TRIO_REQ_W-3], trio_req_q[TRIO_REQ_W-4:0],
                      iface_req_q[0], duo_req_q};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // synchronisers per target domain

   logic [DUO_REQ_W-1:0] duo_rst_n;
   logic [TRIO_REQ_W-1:0] trio_rst_n;
   logic [1:0] iface_rst_n;

   crf_rst_sync #(.WIDTH(DUO_REQ_W), .STAGES(SYNC_STAGES)) u_duo_sync (
      .clk_i(duo_cluster_clk_i),
      .rst_req_i(duo_req_q),
      .rst_n_o(duo_rst_n)
   );

   crf_rst_sync #(.WIDTH(TRIO_REQ_W), .STAGES(SYNC_STAGES)) u_trio_sync (
      .clk_i(trio_cluster_clk_i),
      .rst_req_i(trio_req_q),
      .rst_n_o(trio_rst_n)
   );

   crf_rst_sync #(.WIDTH(2), .STAGES(SYNC_STAGES)) u_iface_sync (
      .clk_i(sys_clk_i),
      .rst_req_i(iface_req_q),
      .rst_n_o(iface_rst_n)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // active-low outputs straight from synchroniser flops

   localparam int DN = CRF_DUO_CORES;
   localparam int TN = CRF_TRIO_CORES;

   assign duo_percore_full_reset_n_o = duo_rst_n[0 +: DN];
   assign duo_percore_exec_reset_n_o = duo_rst_n[DN +: DN];
   assign duo_percore_simd_reset_n_o = duo_rst_n[2*DN +: DN];
   assign duo_percore_debug_reset_n_o = duo_rst_n[3*DN +: DN];
   assign duo_shared_debug_reset_n_o = duo_rst_n[4*DN];
   assign duo_l2_reset_n_o = duo_rst_n[4*DN+1];
   assign duo_core_domain_reset_n_o = duo_rst_n[4*DN+2];
   assign duo_iface_domain_reset_n_o = iface_rst_n[0];

   assign trio_percore_full_reset_n_o = trio_rst_n[0 +: TN];
   assign trio_percore_exec_reset_n_o = trio_rst_n[TN +: TN];
   assign trio_percore_debug_reset_n_o = trio_rst_n[2*TN +: TN];
   assign trio_percore_trace_reset_n_o = trio_rst_n[3*TN +: TN];
   assign trio_system_debug_reset_n_o = trio_rst_n[4*TN];
   assign trio_l2_reset_n_o = trio_rst_n[4*TN+1];
   assign trio_core_domain_reset_n_o = trio_rst_n[4*TN+2];
   assign trio_iface_domain_reset_n_o = iface_rst_n[1];

endmodule : crf_reset_fanout

// file: dv/crf_far_model.sv
// far-side model: free-running cluster and system clocks
// assumes the bench only consumes the clocks
`timescale 1ns/1ps
module crf_far_model (
   // target domain clocks
   output logic duo_clk_o,
   output logic trio_clk_o,
   output logic sys_clk_o
);
   ////////////////////////////////////////
   initial begin
      duo_clk_o = 1'b0;
      trio_clk_o = 1'b0;
      sys_clk_o = 1'b0;
   end
   // unrelated periods, system clock slowest so its release visibly lags
   always #3 duo_clk_o = ~duo_clk_o;
   always #4.1 trio_clk_o = ~trio_clk_o;
   always #97 sys_clk_o = ~sys_clk_o;
endmodule : crf_far_model

// file: dv/crf_reset_fanout_monitor.sv
// checker for the register bus and reset outputs
// assumes byte lanes of reset_control_reg follow wb_sel_i
`timescale 1ns/1ps
module crf_reset_fanout_monitor
   import crf_pkg::*;
(
   // clock, reset and bus
   input wire logic clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
   input wire logic [CRF_ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i, wb_dat_o,
   // watched resets
   input wire logic [1:0] duo_percore_full_reset_n_o, duo_percore_exec_reset_n_o,
   input wire logic [1:0] duo_percore_simd_reset_n_o, duo_percore_debug_reset_n_o,
   input wire logic duo_shared_debug_reset_n_o, duo_l2_reset_n_o, duo_iface_domain_reset_n_o,
   input wire logic [2:0] trio_percore_exec_reset_n_o, trio_percore_debug_reset_n_o,
   input wire logic [2:0] trio_percore_trace_reset_n_o,
   input wire logic trio_system_debug_reset_n_o
);
   ////////////////////////////////////////
   logic [31:0] shadow_q;
   wire wr = wb_ack_o && wb_we_i && wb_adr_i == CRF_ADR_RESET_CTRL && wb_sel_i == 4'hf;
   wire rd = wb_ack_o && !wb_we_i;
   wire wr_any = wb_ack_o && wb_we_i && wb_adr_i == CRF_ADR_RESET_CTRL;
   wire [31:0] lane = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         shadow_q <= CRF_RESET_CTRL_RST;
      end else if (wr_any) begin
         shadow_q <= (shadow_q & ~lane) | (wb_dat_i & lane);
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
   chk_ack_timely: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i) ##1 ce_i |-> wb_ack_o)
      else $error("ack late");
   chk_full_hit: assert property (wr && wb_dat_i[0] |-> ##2 !duo_percore_full_reset_n_o[0])
      else $error("duo full reset missing");
   chk_exec_hit: assert property (wr && wb_dat_i[15] |-> ##2 !trio_percore_exec_reset_n_o[0])
      else $error("trio exec reset missing");
   chk_cdom_all: assert property (wr && wb_dat_i[10] |-> ##2 {duo_percore_full_reset_n_o,
      duo_percore_exec_reset_n_o, duo_percore_simd_reset_n_o, duo_percore_debug_reset_n_o,
      duo_shared_debug_reset_n_o, duo_l2_reset_n_o} == 10'h0) else $error("core domain override missing");
   chk_sysdbg_all: assert property (wr && wb_dat_i[24] |-> ##2 {trio_percore_debug_reset_n_o,
      trio_percore_trace_reset_n_o, trio_system_debug_reset_n_o} == 7'h0) else $error("debug override missing");
   chk_iface_async: assert property (wr && wb_dat_i[11] |-> ##2 !duo_iface_domain_reset_n_o)
      else $error("iface reset slow");
   chk_unmapped_zero: assert property (rd && wb_adr_i != CRF_ADR_RESET_CTRL && wb_adr_i != CRF_ADR_RESET_STAT
      |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
   chk_ctrl_readback: assert property (rd && wb_adr_i == CRF_ADR_RESET_CTRL
      |-> wb_dat_o == (shadow_q & CRF_RESET_CTRL_MASK)) else $error("control readback wrong");
   cover property (wr && wb_dat_i[10]);
   cover property (wr && wb_dat_i[24]);
   cover property (rd && wb_adr_i != CRF_ADR_RESET_CTRL);
   cover property (wb_cyc_i && wb_stb_i && !ce_i);
endmodule : crf_reset_fanout_monitor

bind crf_reset_fanout crf_reset_fanout_monitor mon (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
   .wb_ack_o, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .duo_percore_full_reset_n_o, .duo_percore_exec_reset_n_o,
   .duo_percore_simd_reset_n_o, .duo_percore_debug_reset_n_o, .duo_shared_debug_reset_n_o, .duo_l2_reset_n_o,
   .duo_iface_domain_reset_n_o, .trio_percore_exec_reset_n_o, .trio_percore_debug_reset_n_o,
   .trio_percore_trace_reset_n_o, .trio_system_debug_reset_n_o);

// file: dv/crf_reset_fanout_tb.sv
// self-checking bench for the reset fan-out block
// assumes the far-side model supplies the three target clocks
`timescale 1ns/1ps
module crf_reset_fanout_tb
   import crf_pkg::*;
;
   localparam logic [31:0] COMBO [5] = '{32'h0000_0401, 32'h0100_8000, 32'h0400_4000, 32'hf000_0000, 32'h0};
   logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o, dclk, tclk, sclk;
   logic [CRF_ADR_W-1:0] wb_adr_i = '0;
   logic [3:0] wb_sel_i = 4'hf;
   logic [31:0] wb_dat_i = '0, wb_dat_o;
   logic [1:0] df, de, ds, dd;
   logic [2:0] tf, te, td, tt;
   logic dsh, dl2, dcd, dif, tsd, tl2, tcd, tif;
   wire [27:0] obs = ~{tif, tcd, tl2, tsd, tt, td, te, tf, dif, dcd, dl2, dsh, dd, ds, de, df};
   int error_cnt = 0, checked = 0;
   always #10 clk_i = ~clk_i;
   crf_far_model far (.duo_clk_o(dclk), .trio_clk_o(tclk), .sys_clk_o(sclk));
   crf_reset_fanout #(.SYNC_STAGES(CRF_SYNC_STAGES)) uut (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
      .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .duo_cluster_clk_i(dclk), .trio_cluster_clk_i(tclk),
      .sys_clk_i(sclk), .duo_percore_full_reset_n_o(df), .duo_percore_exec_reset_n_o(de),
      .duo_percore_simd_reset_n_o(ds), .duo_percore_debug_reset_n_o(dd), .duo_shared_debug_reset_n_o(dsh),
      .duo_l2_reset_n_o(dl2), .duo_core_domain_reset_n_o(dcd), .duo_iface_domain_reset_n_o(dif),
      .trio_percore_full_reset_n_o(tf), .trio_percore_exec_reset_n_o(te), .trio_percore_debug_reset_n_o(td),
      .trio_percore_trace_reset_n_o(tt), .trio_system_debug_reset_n_o(tsd), .trio_l2_reset_n_o(tl2),
      .trio_core_domain_reset_n_o(tcd), .trio_iface_domain_reset_n_o(tif));
   ////////////////////////////////////////
   function automatic logic [27:0] exp_of(input logic [31:0] v);
      logic [27:0] e;
      e = v[27:0];
      if (v[24]) e[23:18] = 6'h3f; // debug override
      if (v[10]) e[9:0] = 10'h3ff; // duo domain override
      if (v[26]) e[25:12] = 14'h3fff; // trio domain override
      return e;
   endfunction : exp_of
   task automatic close_out();
      if (error_cnt == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : close_out
   task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
      checked++;
      if (s !== e) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask : cmp
   task automatic idle(input int c);
      repeat (c) @(posedge clk_i);
   endtask : idle
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (wb_ack_o !== 1'b1) begin
         error_cnt++;
         close_out();
      end
   endtask : wb
   ////////////////////////////////////////
   task automatic s_reset_state();
      logic [31:0] q;
      idle(30);
      cmp("outputs after reset", 32'h0, {4'h0, obs});
      wb(1'b0, CRF_ADR_RESET_CTRL, 32'h0, q);
      cmp("ctrl reset value", CRF_RESET_CTRL_RST, q);
   endtask : s_reset_state
   task automatic s_fields();
      logic [31:0] v, q;
      for (int i = 0; i < 33; i++) begin
         v = (i < 28) ? 32'h1 << i : COMBO[i-28];
         wb(1'b1, CRF_ADR_RESET_CTRL, v, q);
         idle(30);
         cmp("reset outputs", {4'h0, exp_of(v)}, {4'h0, obs});
         wb(1'b0, CRF_ADR_RESET_CTRL, 32'h0, q);
         cmp("ctrl readback", v & CRF_RESET_CTRL_MASK, q);
         wb(1'b0, CRF_ADR_RESET_STAT, 32'h0, q);
         cmp("status", {4'h0, exp_of(v)}, q);
      end
   endtask : s_fields
   task automatic s_release();
      logic [31:0] q;
      wb(1'b1, CRF_ADR_RESET_CTRL, 32'h0000_0801, q);
      idle(30);
      wb(1'b1, CRF_ADR_RESET_CTRL, 32'h0, q);
      idle(3);
      cmp("duo full release", 32'h3, {30'h0, df});
      cmp("duo iface held", 32'h0, {31'h0, dif});
      idle(30);
      cmp("duo iface release", 32'h1, {31'h0, dif});
   endtask : s_release
   task automatic s_freeze();
      logic [31:0] q;
      @(posedge clk_i);
      ce_i <= 1'b0;
      wb_sel_i <= 4'h2;
      fork
         wb(1'b1, CRF_ADR_RESET_CTRL, 32'h0fff_ffff, q);
         begin
            idle(6);
            cmp("ack while frozen", 32'h0, {31'h0, wb_ack_o});
            cmp("outputs while frozen", 32'h0, {4'h0, obs});
            ce_i <= 1'b1;
         end
      join
      wb_sel_i <= 4'hf;
      wb(1'b0, CRF_ADR_RESET_CTRL, 32'h0, q);
      cmp("lane readback", 32'h0000_ff00, q);
      idle(30);
      cmp("outputs after lane write", {4'h0, exp_of(32'h0000_ff00)}, {4'h0, obs});
      wb(1'b1, CRF_ADR_RESET_CTRL, 32'h0, q);
      idle(30);
   endtask : s_freeze
   task automatic s_bus();
      logic [31:0] q;
      wb(1'b1, CRF_ADR_RESET_STAT, 32'h0fff_ffff, q);
      wb(1'b1, 8'h10, 32'h0000_0001, q);
      wb(1'b0, 8'h10, 32'h0, q);
      cmp("unmapped read", 32'h0, q);
      wb(1'b0, CRF_ADR_RESET_CTRL, 32'h0, q);
      cmp("ctrl untouched", 32'h0, q);
      idle(30);
      cmp("outputs after ignored writes", 32'h0, {4'h0, obs});
   endtask : s_bus
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      s_reset_state();
      s_fields(); // controller loads the control bank
      s_release();
      s_freeze();
      s_bus();
      close_out();
   end
endmodule : crf_reset_fanout_tb
